// ### hdl/acs_pkg.sv
package acs_pkg;

  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_SEL      = 8'h7c;
  localparam logic [7:0] IDX_CTRL     = 8'h7a;
  localparam logic [7:0] IDX_RES_LO   = 8'h78;
  localparam logic [7:0] IDX_RES_HI   = 8'h79;
  localparam logic [7:0] IDX_MODE     = 8'h70;

  // selection_register fields
  localparam int         SEL_REF_LSB  = 6;
  localparam int         SEL_LJ_BIT   = 5;
  localparam int         SEL_CH_LSB   = 0;
  localparam logic [7:0] SEL_WR_MASK  = 8'hef;

  // control register fields
  localparam int         CTRL_EN_BIT   = 7;
  localparam int         CTRL_START_BIT = 6;
  localparam int         CTRL_ATE_BIT  = 5;
  localparam int         CTRL_DONE_BIT = 4;
  localparam int         CTRL_IE_BIT   = 3;
  localparam int         CTRL_PS_LSB   = 0;

  // mode register: trigger source, 0 = free running, 1 = trigger pin
  localparam int         MODE_TRIG_BIT = 0;

  localparam logic [7:0] RST_SEL      = 8'h00;
  localparam logic [7:0] RST_CTRL     = 8'h00;
  localparam logic [7:0] RST_MODE     = 8'h00;

  // conversion timing in converter clock cycles
  localparam logic [4:0] CONV_CYC_NORMAL = 5'd13;
  localparam logic [4:0] CONV_CYC_FIRST  = 5'd25;
  localparam logic [4:0] SAR_LEAD        = 5'd11;
  localparam logic [9:0] SAR_MSB         = 10'h200;

  localparam logic [2:0] SLEEP_IDLE   = 3'h1;
  localparam logic [2:0] SLEEP_NOISE  = 3'h2;

  typedef enum logic {ACS_ST_IDLE, ACS_ST_CONV} acs_state_e;

endpackage

// ### hdl/acs_sync.sv
`timescale 1ns/1ps
module acs_sync #(
  parameter int W = 2
) (
  input  wire logic         core_clk_in,
  input  wire logic         reset_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } acs_sync_s;

  acs_sync_s q;
  acs_sync_s d;
  logic [W-1:0] agree;

  always_comb
  begin
    d     = q;
    agree = ~(q.s2 ^ q.s3);
    d.s1  = async_in;
    d.s2  = q.s1;
    d.s3  = q.s2;
    // a change counts once the second and third stages agree
    d.out = (agree & q.s3) | (~agree & q.out);
  end

  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
      q <= '0;
    else
      q <= d;
  end

  assign sync_out = q.out;

endmodule

// ### hdl/acs_prescaler.sv
`timescale 1ns/1ps
module acs_prescaler (
  input  wire logic       core_clk_in,
  input  wire logic       reset_in,
  input  wire logic [2:0] div_sel_in,
  input  wire logic       clear_in,
  output logic            tick_out
);

  typedef struct packed {
    logic [6:0] cnt;
    logic       tick;
  } acs_presc_s;

  acs_presc_s q;
  acs_presc_s d;
  logic [6:0] limit;

  always_comb
  begin
    d     = q;
    // divide by 2 for codes 0 and 1, else by two to the code
    limit = (div_sel_in == 3'h0) ? 7'h01 : 7'((8'h01 << div_sel_in) - 8'h01);
    d.tick = 1'b0;
    if (clear_in)
      d.cnt = 7'h00;
    else if (q.cnt >= limit)
    begin
      d.cnt  = 7'h00;
      d.tick = 1'b1;
    end
    else
      d.cnt = q.cnt + 7'h01;
  end

  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
      q <= '0;
    else
      q <= d;
  end

  assign tick_out = q.tick;

  a_tick_cleared: assert property (@(posedge core_clk_in) disable iff (reset_in)
    clear_in |=> !tick_out ##1 !tick_out)
    else $error("converter tick right after prescaler clear");

endmodule

// ### hdl/acs_top.sv
// What this block does
// - selection held in a temporary register, copied to active selection while idle.
// - active channel and reference frozen once a conversion begins.
// - copying resumes in the last converter cycle before completion.
// - a written start bit begins conversion at next converter clock edge.
// - a selection written at a safe moment applies to the next conversion.
// - free running: change after a completion hits the conversion after next.
// - input above reference on single ended channel gives code near 0x3ff.
// - enabled idle single mode with interrupt enabled starts converting on halt in idle or noise sleep mode.
// - conversion started in sleep still raises its interrupt after an early wake.
// - other sleep modes never turn the converter off by themselves.
// - result readable in low and high result registers once done flag sets.
// - result is vin times 1024 over reference, 0x000 ground, 0x3ff top.
// - start bit reads one while converting, clears on completion in single mode.
// - conversions last 13 converter cycles, 25 for the first after enabling.
// - auto trigger rising edge resets prescaler and starts; edges while busy ignored.
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module acs_top (
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  input  wire logic [9:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        comparator_in,
  input  wire logic        trigger_in,
  input  wire logic        cpu_halted_in,
  input  wire logic [2:0]  sleep_mode_in,
  input  wire logic        irq_ack_in,
  output logic      [3:0]  channel_select_out,
  output logic      [1:0]  reference_select_out,
  output logic      [9:0]  dac_code_out,
  output logic             sample_hold_out,
  output logic             converter_on_out,
  output logic             conv_irq_out
);

  typedef struct packed {
    acs_pkg::acs_state_e state;
    logic [7:0]          sel_tmp;
    logic [5:0]          sel_act;
    logic                en;
    logic                ate;
    logic                ie;
    logic                done;
    logic [2:0]          ps;
    logic                trig_src;
    logic                start_pend;
    logic                first;
    logic [4:0]          cnt;
    logic [4:0]          len;
    logic [9:0]          sar;
    logic [9:0]          mask;
    logic [9:0]          result;
    logic                lock;
    logic                halted_prev;
    logic                trig_prev;
    logic                ack;
    logic [31:0]         rdata;
    logic [4:0]          hc;
  } acs_top_s;

  localparam logic [9:0] ADDR_SEL    = {acs_pkg::IDX_SEL, 2'b00};
  localparam logic [9:0] ADDR_CTRL   = {acs_pkg::IDX_CTRL, 2'b00};
  localparam logic [9:0] ADDR_RES_LO = {acs_pkg::IDX_RES_LO, 2'b00};
  localparam logic [9:0] ADDR_RES_HI = {acs_pkg::IDX_RES_HI, 2'b00};
  localparam logic [9:0] ADDR_MODE   = {acs_pkg::IDX_MODE, 2'b00};

  acs_top_s   q;
  acs_top_s   d;
  logic       tick;
  logic       comp_s;
  logic       trig_s;
  logic       presc_clear;
  logic       trig_start;
  logic       sleep_start;
  logic       begin_now;
  logic       complete;
  logic       free_run;
  logic       wr;
  logic       rd;
  logic       start_bit;
  logic [7:0] rd_byte;
  logic [7:0] res_lo;
  logic [7:0] res_hi;
  logic [7:0] wd;

  acs_sync #(
    .W (2)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .async_in    ({comparator_in, trigger_in}),
    .sync_out    ({comp_s, trig_s})
  );

  acs_prescaler u_presc (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .div_sel_in  (q.ps),
    .clear_in    (presc_clear),
    .tick_out    (tick)
  );

  always_comb
  begin
    d = q;
    wd = avs_writedata_in[7:0];
    wr = avs_write_in & q.ack & avs_byteenable_in[0];
    rd = avs_read_in & q.ack;
    free_run = q.ate & ~q.trig_src;
    start_bit = (q.state == acs_pkg::ACS_ST_CONV) | q.start_pend;
    // left justify acts at once on the result view
    if (q.sel_tmp[acs_pkg::SEL_LJ_BIT])
    begin
      res_hi = q.result[9:2];
      res_lo = {q.result[1:0], 6'h00};
    end
    else
    begin
      res_hi = {6'h00, q.result[9:8]};
      res_lo = q.result[7:0];
    end
    case (avs_address_in)
      ADDR_SEL:    rd_byte = q.sel_tmp;
      ADDR_CTRL:   rd_byte = {q.en, start_bit, q.ate, q.done, q.ie, q.ps};
      ADDR_RES_LO: rd_byte = res_lo;
      ADDR_RES_HI: rd_byte = res_hi;
      ADDR_MODE:   rd_byte = {7'h00, q.trig_src};
      default:     rd_byte = 8'h00;
    endcase

    // bus handshake: one wait cycle, data loaded as the wait ends
    d.ack = (avs_read_in | avs_write_in) & ~q.ack;
    if (avs_read_in & ~q.ack)
      d.rdata = {24'h000000, rd_byte};

    d.trig_prev   = trig_s;
    d.halted_prev = cpu_halted_in;
    trig_start  = q.en & q.ate & q.trig_src & trig_s & ~q.trig_prev
                & (q.state == acs_pkg::ACS_ST_IDLE) & ~q.start_pend;
    sleep_start = q.en & ~q.ate & q.ie & (q.state == acs_pkg::ACS_ST_IDLE) & ~q.start_pend
                & cpu_halted_in & ~q.halted_prev
                & ((sleep_mode_in == acs_pkg::SLEEP_IDLE) | (sleep_mode_in == acs_pkg::SLEEP_NOISE));
    // other sleep modes leave the enable alone
    presc_clear = ~q.en | trig_start;
    begin_now = tick & q.en & q.start_pend & (q.state == acs_pkg::ACS_ST_IDLE);
    complete  = tick & (q.state == acs_pkg::ACS_ST_CONV) & (q.cnt == q.len - 5'd1);

    // active selection follows the temporary one only while unlocked
    if ((q.state == acs_pkg::ACS_ST_IDLE) || (q.cnt == q.len - 5'd1))
      d.sel_act = {q.sel_tmp[acs_pkg::SEL_REF_LSB +: 2], q.sel_tmp[acs_pkg::SEL_CH_LSB +: 4]};

    if (sleep_start | trig_start)
      d.start_pend = 1'b1;
    if (tick)
      d.hc = q.hc + 5'd1;

    if (begin_now)
    begin
      d.state      = acs_pkg::ACS_ST_CONV;
      d.cnt        = 5'd0;
      d.len        = q.first ? acs_pkg::CONV_CYC_FIRST : acs_pkg::CONV_CYC_NORMAL;
      d.first      = 1'b0;
      d.start_pend = 1'b0;
      d.sar        = acs_pkg::SAR_MSB;
      d.mask       = acs_pkg::SAR_MSB;
      d.hc         = 5'd0;
    end
    else if (complete)
    begin
      d.done = 1'b1;
      if (~q.lock)
        d.result = q.sar;
      if (free_run)
      begin
        // next conversion starts at once on the just locked selection
        d.cnt  = 5'd0;
        d.len  = acs_pkg::CONV_CYC_NORMAL;
        d.sar  = acs_pkg::SAR_MSB;
        d.mask = acs_pkg::SAR_MSB;
        d.hc   = 5'd0;
      end
      else
        d.state = acs_pkg::ACS_ST_IDLE;
    end
    else if (tick & (q.state == acs_pkg::ACS_ST_CONV))
    begin
      d.cnt = q.cnt + 5'd1;
      // successive approximation; comparator high keeps the trial bit
      if ((q.cnt >= q.len - acs_pkg::SAR_LEAD) && (q.mask != 10'h000))
      begin
        d.sar  = (comp_s ? q.sar : (q.sar & ~q.mask)) | (q.mask >> 1);
        d.mask = q.mask >> 1;
      end
    end

    // vector clear; a completion in the same cycle wins
    if (irq_ack_in & ~complete)
      d.done = 1'b0;

    if (wr)
    begin
      case (avs_address_in)
        ADDR_SEL:
          d.sel_tmp = wd & acs_pkg::SEL_WR_MASK;
        ADDR_MODE:
          d.trig_src = wd[acs_pkg::MODE_TRIG_BIT];
        ADDR_CTRL:
        begin
          d.en  = wd[acs_pkg::CTRL_EN_BIT];
          d.ate = wd[acs_pkg::CTRL_ATE_BIT];
          d.ie  = wd[acs_pkg::CTRL_IE_BIT];
          d.ps  = wd[acs_pkg::CTRL_PS_LSB +: 3];
          if (wd[acs_pkg::CTRL_EN_BIT] & ~q.en)
            d.first = 1'b1;
          if (wd[acs_pkg::CTRL_START_BIT] & wd[acs_pkg::CTRL_EN_BIT] & ~start_bit)
            d.start_pend = 1'b1;
          // write one clears the flag; a completion in the same cycle wins
          if (wd[acs_pkg::CTRL_DONE_BIT] & ~complete)
            d.done = 1'b0;
        end
        default:
          d.sel_tmp = q.sel_tmp;
      endcase
    end
    if (rd && (avs_address_in == ADDR_RES_LO))
      d.lock = 1'b1;
    if (rd && (avs_address_in == ADDR_RES_HI))
      d.lock = 1'b0;

    // disabling ends any conversion in flight
    if (~q.en)
    begin
      d.state      = acs_pkg::ACS_ST_IDLE;
      d.start_pend = d.start_pend & d.en;
      d.mask       = 10'h000;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      q          <= '0;
      q.state    <= acs_pkg::ACS_ST_IDLE;
      q.sel_tmp  <= acs_pkg::RST_SEL;
      q.trig_src <= acs_pkg::RST_MODE[acs_pkg::MODE_TRIG_BIT];
      q.en       <= acs_pkg::RST_CTRL[acs_pkg::CTRL_EN_BIT];
    end
    else
      q <= d;
  end

  assign avs_waitrequest_out  = (avs_read_in | avs_write_in) & ~q.ack;
  assign avs_readdata_out     = q.rdata;
  assign channel_select_out   = q.sel_act[3:0];
  assign reference_select_out = q.sel_act[5:4];
  assign dac_code_out         = q.sar;
  assign sample_hold_out      = (q.state == acs_pkg::ACS_ST_CONV) && (q.cnt < q.len - acs_pkg::SAR_LEAD);
  assign converter_on_out     = q.en;
  assign conv_irq_out         = q.done & q.ie;

  a_sel_idle_follow:
    assert property (@(posedge core_clk_in) disable iff (reset_in)
      (q.state == acs_pkg::ACS_ST_IDLE) |=> (channel_select_out == $past(q.sel_tmp[3:0])))
    else $error("active channel did not follow temporary while idle");

  a_sel_frozen:
    assert property (@(posedge core_clk_in) disable iff (reset_in)
      (q.state == acs_pkg::ACS_ST_CONV && q.cnt != q.len - 5'd1)
      |=> $stable(channel_select_out) && $stable(reference_select_out))
    else $error("selection changed during conversion");

  a_sel_last_copy:
    assert property (@(posedge core_clk_in) disable iff (reset_in)
      (q.state == acs_pkg::ACS_ST_CONV && q.cnt == q.len - 5'd1)
      |=> (reference_select_out == $past(q.sel_tmp[7:6])))
    else $error("selection not copied in last converter cycle");

  a_start_on_tick:
    assert property (@(posedge core_clk_in) disable iff (reset_in)
      (q.state == acs_pkg::ACS_ST_IDLE && q.en && q.start_pend && tick)
      |=> (q.state == acs_pkg::ACS_ST_CONV && q.cnt == 5'd0))
    else $error("conversion did not begin at converter edge");

  a_conv_length:
    assert property (@(posedge core_clk_in) disable iff (reset_in)
      complete |-> ((q.hc + 5'd1 == q.len)
        && (q.len == acs_pkg::CONV_CYC_NORMAL || q.len == acs_pkg::CONV_CYC_FIRST)))
    else $error("conversion length not 13 or 25 converter cycles");

  a_first_long:
    assert property (@(posedge core_clk_in) disable iff (reset_in)
      (begin_now && q.first) |=> (q.len == acs_pkg::CONV_CYC_FIRST))
    else $error("first conversion after enable not 25 cycles");

  a_done_result:
    assert property (@(posedge core_clk_in) disable iff (reset_in)
      (complete && !q.lock && !irq_ack_in) |=> (q.done && q.result == $past(q.sar)))
    else $error("done flag or result missing after completion");

  a_start_clears:
    assert property (@(posedge core_clk_in) disable iff (reset_in)
      (complete && !free_run && !trig_start && !sleep_start && !(avs_write_in && q.ack))
      |=> !start_bit)
    else $error("start bit still set after single conversion");

  a_trig_ignored:
    assert property (@(posedge core_clk_in) disable iff (reset_in)
      (q.state == acs_pkg::ACS_ST_CONV && q.en && !complete && trig_s && !q.trig_prev)
      |-> !presc_clear ##1 (q.state == acs_pkg::ACS_ST_CONV && !q.start_pend))
    else $error("trigger accepted during conversion");

  a_sleep_start:
    assert property (@(posedge core_clk_in) disable iff (reset_in)
      sleep_start && q.en && !(avs_write_in && q.ack) |=> q.start_pend)
    else $error("sleep halt did not request conversion");

  a_irq_raise:
    assert property (@(posedge core_clk_in) disable iff (reset_in)
      (complete && q.ie && !irq_ack_in && !(avs_write_in && q.ack)) |=> conv_irq_out)
    else $error("completion interrupt request not raised");

endmodule

// ### tb/acs_top_bench.sv
`timescale 1ns/1ps
module acs_top_bench;
  localparam int N = 16;
  typedef struct {logic [7:0] sel; int vin; logic [7:0] lo; logic [7:0] hi;} acs_row_s;
  logic        core_clk_in         = 1'b0;
  logic        reset_in            = 1'b1;
  logic [9:0]  avs_address_in      = 10'h000;
  logic        avs_read_in         = 1'b0;
  logic        avs_write_in        = 1'b0;
  logic [31:0] avs_writedata_in    = 32'h0;
  logic [3:0]  avs_byteenable_in   = 4'hf;
  logic        comparator_in       = 1'b0;
  logic        trigger_in          = 1'b0;
  logic        cpu_halted_in       = 1'b0;
  logic [2:0]  sleep_mode_in       = 3'h0;
  logic        irq_ack_in          = 1'b0;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic [3:0]  channel_select_out;
  logic [1:0]  reference_select_out;
  logic [9:0]  dac_code_out;
  logic        sample_hold_out;
  logic        converter_on_out;
  logic        conv_irq_out;
  int          mismatches          = 0;
  int          n_compared          = 0;
  int          vin                 = 0;
  int          n;
  logic [31:0] q;
  logic [7:0]  idxs [6]            = '{acs_pkg::IDX_SEL, acs_pkg::IDX_CTRL, acs_pkg::IDX_MODE,
                                       acs_pkg::IDX_RES_LO, acs_pkg::IDX_RES_HI, 8'h05};
  acs_row_s    rows [6]            = '{'{8'h43, 0, 8'h00, 8'h00}, '{8'hc5, 677, 8'ha5, 8'h02},
                                       '{8'h67, 677, 8'h40, 8'ha9}, '{8'h0f, 1100, 8'hff, 8'h03},
                                       '{8'h2e, 1023, 8'hc0, 8'hff}, '{8'h01, 1, 8'h01, 8'h00}};

  always #12.5 core_clk_in = ~core_clk_in;

  // ideal comparator: input level in code steps against the trial code
  always @(posedge core_clk_in)
  begin
    comparator_in <= (vin >= int'(dac_code_out));
  end

  acs_top dut (
    .core_clk_in         (core_clk_in),
    .reset_in            (reset_in),
    .avs_address_in      (avs_address_in),
    .avs_read_in         (avs_read_in),
    .avs_write_in        (avs_write_in),
    .avs_writedata_in    (avs_writedata_in),
    .avs_byteenable_in   (avs_byteenable_in),
    .avs_readdata_out    (avs_readdata_out),
    .avs_waitrequest_out (avs_waitrequest_out),
    .comparator_in       (comparator_in),
    .trigger_in          (trigger_in),
    .cpu_halted_in       (cpu_halted_in),
    .sleep_mode_in       (sleep_mode_in),
    .irq_ack_in          (irq_ack_in),
    .channel_select_out  (channel_select_out),
    .reference_select_out(reference_select_out),
    .dac_code_out        (dac_code_out),
    .sample_hold_out     (sample_hold_out),
    .converter_on_out    (converter_on_out),
    .conv_irq_out        (conv_irq_out)
  );

  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one request held until waitrequest seen low, then one idle edge
  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
    int  k;
    logic w;
    k = 0;
    w = 1'b1;
    avs_address_in    <= {idx, 2'b00};
    avs_read_in       <= ~wr;
    avs_write_in      <= wr;
    avs_writedata_in  <= {24'h0, d};
    avs_byteenable_in <= be;
    while (w !== 1'b0)
    begin
      @(negedge core_clk_in);
      w = avs_waitrequest_out;
      q = avs_readdata_out;
      @(posedge core_clk_in);
      k++;
      if (k > 20)
      begin
        mismatches++;
        stop_test();
      end
    end
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge core_clk_in);
  endtask

  task wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'hf);
  endtask

  task rd(input string what, input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, 4'hf);
    chk(what, {24'h0, exp}, q);
  endtask

  task sel_is(input logic [5:0] exp);
    @(negedge core_clk_in);
    chk("active selection", {26'h0, exp}, {26'h0, reference_select_out, channel_select_out});
    @(posedge core_clk_in);
  endtask

  // cycles until the completion request shows, counted on falling edges
  task wait_irq(output int c);
    c = 0;
    do
    begin
      @(negedge core_clk_in);
      c++;
      if (c > 30 * N)
      begin
        mismatches++;
        stop_test();
      end
    end while (conv_irq_out !== 1'b1);
    @(posedge core_clk_in);
  endtask

  initial
  begin
    repeat (16) @(posedge core_clk_in);
    reset_in <= 1'b0;
    @(posedge core_clk_in);
    wr(8'h05, 8'hff);
    wr(acs_pkg::IDX_RES_LO, 8'hff);
    bus(1'b1, acs_pkg::IDX_SEL, 8'hff, 4'he);
    foreach (idxs[i])
      rd("reset value", idxs[i], 8'h00);
    chk("converter on", 32'h0, {31'h0, converter_on_out});
    // first conversion: enable and start in one write
    vin = 5;
    wr(acs_pkg::IDX_SEL, 8'h42);
    wr(acs_pkg::IDX_CTRL, 8'hcc);
    repeat (N) @(posedge core_clk_in);
    wr(acs_pkg::IDX_SEL, 8'h49);
    @(negedge core_clk_in);
    chk("sample hold", 32'h1, {31'h0, sample_hold_out});
    sel_is(6'h12);
    wait_irq(n);
    // cycles from start write landing: first tick after enable, then 25 ticks
    chk("first length", 32'h1, {31'h0, (N + 5 + n >= 25 * N + 1) && (N + 5 + n <= 26 * N + 1)});
    sel_is(6'h19);
    rd("first result", acs_pkg::IDX_RES_LO, 8'h05);
    rd("first result high", acs_pkg::IDX_RES_HI, 8'h00);
    wr(acs_pkg::IDX_CTRL, 8'h9c);
    foreach (rows[i])
    begin
      vin = rows[i].vin;
      wr(acs_pkg::IDX_SEL, rows[i].sel);
      sel_is({rows[i].sel[7:6], rows[i].sel[3:0]});
      wr(acs_pkg::IDX_CTRL, 8'hcc);
      rd("start while busy", acs_pkg::IDX_CTRL, 8'hcc);
      wait_irq(n);
      chk("normal length", 32'h1, {31'h0, (n + 3 >= 13 * N + 1) && (n + 3 <= 14 * N)});
      rd("start after done", acs_pkg::IDX_CTRL, 8'h9c);
      rd("result low", acs_pkg::IDX_RES_LO, rows[i].lo);
      rd("result high", acs_pkg::IDX_RES_HI, rows[i].hi);
      wr(acs_pkg::IDX_CTRL, 8'h9c);
    end
    // free running: change after first completion
    // reference switched here; results of this run are never read
    wr(acs_pkg::IDX_SEL, 8'h43);
    wr(acs_pkg::IDX_CTRL, 8'hec);
    wait_irq(n);
    wr(acs_pkg::IDX_SEL, 8'h06);
    sel_is(6'h13);
    wr(acs_pkg::IDX_CTRL, 8'hbc);
    wait_irq(n);
    sel_is(6'h06);
    // disable and clear the leftover done flag
    wr(acs_pkg::IDX_CTRL, 8'h1c);
    // pin trigger: third edge, during the second conversion, is ignored
    wr(acs_pkg::IDX_MODE, 8'h01);
    wr(acs_pkg::IDX_CTRL, 8'hac);
    trigger_in <= 1'b1;
    wait_irq(n);
    wr(acs_pkg::IDX_CTRL, 8'hbc);
    trigger_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    trigger_in <= 1'b1;
    repeat (4 * N) @(posedge core_clk_in);
    trigger_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    trigger_in <= 1'b1;
    wait_irq(n);
    wr(acs_pkg::IDX_CTRL, 8'hbc);
    repeat (20 * N) @(posedge core_clk_in);
    chk("extra trigger", 32'h0, {31'h0, conv_irq_out});
    // sleep starts; early wake; mode 3 starts nothing
    wr(acs_pkg::IDX_MODE, 8'h00);
    wr(acs_pkg::IDX_CTRL, 8'h8c);
    for (int m = 1; m <= 3; m++)
    begin
      sleep_mode_in <= m[2:0];
      cpu_halted_in <= 1'b1;
      repeat (2 * N) @(posedge core_clk_in);
      cpu_halted_in <= 1'b0;
      if (m < 3)
      begin
        wait_irq(n);
        irq_ack_in <= 1'b1;
        @(posedge core_clk_in);
        irq_ack_in <= 1'b0;
      end
      else
        repeat (20 * N) @(posedge core_clk_in);
      @(negedge core_clk_in);
      chk("irq after sleep", 32'h0, {31'h0, conv_irq_out});
      chk("converter on", 32'h1, {31'h0, converter_on_out});
      @(posedge core_clk_in);
    end
    stop_test();
  end
endmodule
